// ===== rtl/wdt_pkg.sv
/*
  Package for the watchdog block: register offsets, field positions,
  reset values, the unlock key and the bus/status carriers.
  Assumes a 32-bit AHB-Lite register bus and a single system clock.
*/
package wdt_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_RELOAD  = 8'h00;
  localparam logic [7:0] OFF_VALUE   = 8'h04;
  localparam logic [7:0] OFF_CTRL    = 8'h08;
  localparam logic [7:0] OFF_ICLR    = 8'h0c;
  localparam logic [7:0] OFF_RIS     = 8'h10;
  localparam logic [7:0] OFF_MIS     = 8'h14;
  localparam logic [7:0] OFF_IMASK   = 8'h18;
  localparam logic [7:0] OFF_LOCK    = 8'h1c;
  localparam logic [7:0] OFF_STATUS  = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_RESEN_BIT  = 1;
  localparam int CTRL_STALL_BIT  = 2;
  localparam int STAT_RUN_BIT    = 0;
  localparam int STAT_LOCK_BIT   = 1;
  localparam int INT_TMO_BIT     = 0;

  // ----------------------------------------------------------------
  // reset values and key
  // ----------------------------------------------------------------
  localparam logic [31:0] RELOAD_RST = 32'hffffffff;
  localparam logic [2:0]  CTRL_RST   = 3'h0;
  localparam logic        IMASK_RST  = 1'h0;
  localparam logic        LOCK_RST   = 1'h0;
  localparam logic [31:0] UNLOCK_KEY = 32'h1acce551;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        run;
    logic        locked;
  } wdt_stat_t;

endpackage

// ===== rtl/wdt_ahb_slave.sv
/*
  AHB-Lite slave front end: captures the address phase and presents a
  one-cycle register request in the data phase; zero wait states.
  Assumes a single master and whole-word transfers.
*/
`timescale 1ns/1ps
`default_nettype none
module wdt_ahb_slave
  import wdt_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output reg_req_t         req_o
);

  logic       wr_ph;
  logic       rd_ph;
  logic [7:0] addr_ph;
  logic       next_wr_ph;
  logic       next_rd_ph;
  logic [7:0] next_addr_ph;

  // ----------------------------------------------------------------
  // address phase capture
  // ----------------------------------------------------------------
  always_comb begin
    next_wr_ph   = 1'b0;
    next_rd_ph   = 1'b0;
    next_addr_ph = addr_ph;
    if (hsel_i && hready_i && htrans_i[1]) begin
      next_wr_ph   = hwrite_i;
      next_rd_ph   = ~hwrite_i;
      next_addr_ph = haddr_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ph   <= 1'b0;
      rd_ph   <= 1'b0;
      addr_ph <= 8'h00;
    end else begin
      wr_ph   <= next_wr_ph;
      rd_ph   <= next_rd_ph;
      addr_ph <= next_addr_ph;
    end
  end

  assign req_o.wr    = wr_ph;
  assign req_o.rd    = rd_ph;
  assign req_o.addr  = addr_ph;
  assign req_o.wdata = hwdata_i;

endmodule
`default_nettype wire

// ===== rtl/wdt_counter.sv
/*
  Watchdog down-counter: decrements while running and not stalled,
  reloads on load request or on reaching zero, flags each timeout.
  Assumes load and stall inputs synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module wdt_counter #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             run_i,
  input  wire logic             freeze_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] load_val_i,
  output logic [WIDTH-1:0]      count_o,
  output logic                  timeout_o
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             tmo;
  logic             next_tmo;

  // ----------------------------------------------------------------
  // count and timeout
  // ----------------------------------------------------------------
  always_comb begin
    next_count = count;
    next_tmo   = 1'b0;
    if (load_i) begin
      next_count = load_val_i;
      next_tmo   = run_i && (load_val_i == '0);
    end else if (run_i && !freeze_i) begin
      if (count == '0) begin
        next_count = load_val_i;
      end else begin
        next_count = count - 1'b1;
        next_tmo   = (count == {{(WIDTH-1){1'b0}}, 1'b1});
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count <= '1;
      tmo   <= 1'b0;
    end else begin
      count <= next_count;
      tmo   <= next_tmo;
    end
  end

  assign count_o   = count;
  assign timeout_o = tmo;

endmodule
`default_nettype wire

// ===== rtl/wdt_top.sv
/*
  Watchdog timer with interrupt on first timeout, optional processor
  reset on second, debug stall and a keyed write lock.
  Assumes AHB-Lite register access and a halted flag from debug logic.
*/
`timescale 1ns/1ps
`default_nettype none
module wdt_top
  import wdt_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic        HREADY_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        DBG_HALT_I,
  output logic [31:0]      HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  output logic             IRQ_O,
  output logic             CPU_RESET_O
);

  reg_req_t         req;
  logic [WIDTH-1:0] count;
  logic             tmo;

  logic [WIDTH-1:0] reload;
  logic [2:0]       ctrl;
  logic             raw;
  logic             imask;
  logic             locked;
  logic             rst_out;
  logic             irq;
  logic [31:0]      rdata;
  logic             load_req;

  logic [WIDTH-1:0] next_reload;
  logic [2:0]       next_ctrl;
  logic             next_raw;
  logic             next_imask;
  logic             next_locked;
  logic             next_rst_out;
  logic             next_irq;
  logic [31:0]      next_rdata;
  logic             next_load_req;

  wdt_stat_t        stat;
  logic             cfg_wr;

  // ----------------------------------------------------------------
  // bus front end and counter
  // ----------------------------------------------------------------
  wdt_ahb_slave u_bus (
    .clk_i    (CLK_I),
    .rst_n_i  (RST_N_I),
    .hsel_i   (HSEL_I),
    .haddr_i  (HADDR_I),
    .htrans_i (HTRANS_I),
    .hwrite_i (HWRITE_I),
    .hready_i (HREADY_I),
    .hwdata_i (HWDATA_I),
    .req_o    (req)
  );

  wdt_counter #(
    .WIDTH (WIDTH)
  ) u_cnt (
    .clk_i      (CLK_I),
    .rst_n_i    (RST_N_I),
    .run_i      (ctrl[CTRL_EN_BIT]),
    .freeze_i   (ctrl[CTRL_STALL_BIT] && DBG_HALT_I),
    .load_i     (load_req),
    .load_val_i (reload),
    .count_o    (count),
    .timeout_o  (tmo)
  );

  assign stat.run    = ctrl[CTRL_EN_BIT];
  assign stat.locked = locked;
  assign cfg_wr      = req.wr && !locked;

  // ----------------------------------------------------------------
  // register writes, interrupt and reset
  // ----------------------------------------------------------------
  always_comb begin
    next_reload   = reload;
    next_ctrl     = ctrl;
    next_raw      = raw;
    next_imask    = imask;
    next_locked   = locked;
    next_rst_out  = 1'b0;
    next_load_req = 1'b0;
    if (cfg_wr) begin
      if (req.addr == OFF_RELOAD) begin
        next_reload   = req.wdata[WIDTH-1:0];
        next_load_req = ctrl[CTRL_EN_BIT];
      end else if (req.addr == OFF_CTRL) begin
        // enable is sticky once set, as in a usual watchdog
        next_ctrl[CTRL_EN_BIT]    = ctrl[CTRL_EN_BIT] | req.wdata[CTRL_EN_BIT];
        next_ctrl[CTRL_RESEN_BIT] = req.wdata[CTRL_RESEN_BIT];
        next_ctrl[CTRL_STALL_BIT] = req.wdata[CTRL_STALL_BIT];
        if (req.wdata[CTRL_EN_BIT] && !ctrl[CTRL_EN_BIT]) begin
          next_load_req = 1'b1;
        end
      end else if (req.addr == OFF_ICLR) begin
        if (req.wdata[INT_TMO_BIT]) begin
          next_raw = 1'b0;
        end
      end else if (req.addr == OFF_IMASK) begin
        next_imask = req.wdata[INT_TMO_BIT];
      end
    end
    if (req.wr && req.addr == OFF_LOCK) begin
      next_locked = (req.wdata != UNLOCK_KEY);
    end
    if (tmo) begin
      if (raw && ctrl[CTRL_RESEN_BIT]) begin
        next_rst_out = 1'b1;
      end
      next_raw = 1'b1;
    end
    next_irq = next_raw && next_imask;
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h00000000;
    if (HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I) begin
      if (HADDR_I[7:0] == OFF_RELOAD) begin
        next_rdata[WIDTH-1:0] = reload;
      end else if (HADDR_I[7:0] == OFF_VALUE) begin
        next_rdata[WIDTH-1:0] = count;
      end else if (HADDR_I[7:0] == OFF_CTRL) begin
        next_rdata[2:0] = ctrl;
      end else if (HADDR_I[7:0] == OFF_RIS) begin
        next_rdata[INT_TMO_BIT] = raw;
      end else if (HADDR_I[7:0] == OFF_MIS) begin
        next_rdata[INT_TMO_BIT] = raw && imask;
      end else if (HADDR_I[7:0] == OFF_IMASK) begin
        next_rdata[INT_TMO_BIT] = imask;
      end else if (HADDR_I[7:0] == OFF_LOCK) begin
        next_rdata[0] = stat.locked;
      end else if (HADDR_I[7:0] == OFF_STATUS) begin
        next_rdata[STAT_RUN_BIT]  = stat.run;
        next_rdata[STAT_LOCK_BIT] = stat.locked;
      end
    end else begin
      next_rdata = rdata;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      reload   <= RELOAD_RST[WIDTH-1:0];
      ctrl     <= CTRL_RST;
      raw      <= 1'b0;
      imask    <= IMASK_RST;
      locked   <= LOCK_RST;
      rst_out  <= 1'b0;
      irq      <= 1'b0;
      rdata    <= 32'h00000000;
      load_req <= 1'b0;
    end else begin
      reload   <= next_reload;
      ctrl     <= next_ctrl;
      raw      <= next_raw;
      imask    <= next_imask;
      locked   <= next_locked;
      rst_out  <= next_rst_out;
      irq      <= next_irq;
      rdata    <= next_rdata;
      load_req <= next_load_req;
    end
  end

  assign HRDATA_O    = rdata;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
  assign IRQ_O       = irq;
  assign CPU_RESET_O = rst_out;

endmodule
`default_nettype wire

// ===== verification/wdt_top_sva.sv
/*
  Checker for wdt_top: bus response, read formats, interrupt and reset pulses.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module wdt_top_sva
  import wdt_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input wire logic        CLK_I,
  input wire logic        RST_N_I,
  input wire logic        HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0]  HTRANS_I,
  input wire logic        HWRITE_I,
  input wire logic        HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic        HREADYOUT_O,
  input wire logic        HRESP_O,
  input wire logic        IRQ_O,
  input wire logic        CPU_RESET_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic       ap;
  logic       rd;
  logic [3:0] wr_h;
  logic [3:0] next_wr_h;
  assign ap = HSEL_I & HREADY_I & HTRANS_I[1];
  assign rd = ap & !HWRITE_I;
  // recent write address phases
  always_comb next_wr_h = {wr_h[2:0], ap & HWRITE_I};
  always_ff @(posedge CLK_I) wr_h <= RST_N_I ? next_wr_h : 4'h0;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_ready_high: assert property (HREADYOUT_O)
    else $error("ready dropped");
  a_resp_okay: assert property (!HRESP_O)
    else $error("error response");
  a_reset_quiet: assert property ($rose(RST_N_I) |-> !IRQ_O && !CPU_RESET_O && HRDATA_O == 32'h0)
    else $error("outputs not quiet after reset");
  a_pulse_single: assert property (CPU_RESET_O |=> !CPU_RESET_O)
    else $error("reset pulse too long");
  a_unmapped_zero: assert property (rd && HADDR_I[7:0] > OFF_STATUS |=> HRDATA_O == 32'h0)
    else $error("unmapped read not zero");
  a_status_bits: assert property (rd && HADDR_I[7:0] == OFF_STATUS |=> HRDATA_O[31:2] == 30'h0)
    else $error("status spare bits set");
  a_mis_onebit: assert property (rd && HADDR_I[7:0] == OFF_MIS |=> HRDATA_O[31:1] == 31'h0)
    else $error("masked status spare bits set");
  a_irq_fall: assert property ($fell(IRQ_O) && $past(RST_N_I) |-> |wr_h)
    else $error("interrupt fell without a write");
  c_cpu_reset: cover property (CPU_RESET_O);
  c_irq_fall: cover property ($fell(IRQ_O));
  c_status_rd: cover property (rd && HADDR_I[7:0] == OFF_STATUS);
endmodule
bind wdt_top wdt_top_sva #(.WIDTH(WIDTH)) u_sva (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
  .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O),
  .HRESP_O(HRESP_O), .IRQ_O(IRQ_O), .CPU_RESET_O(CPU_RESET_O));
`default_nettype wire

// ===== verification/wdt_top_bench.sv
/*
  Bench for wdt_top: bus tasks, register model, timeout scenarios.
  Assumes zero wait states and a registered read path.
*/
`timescale 1ns/1ps
`default_nettype none
module wdt_top_bench
  import wdt_pkg::*;
;
  logic        clk, rst_n, hwrite, halt, hready, hresp, irq, cpu_rst, lk;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, r, v0, seed, big, sml;
  logic [31:0] mdl [logic [7:0]];
  int          mismatches, samples_checked;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  wdt_top #(.WIDTH(32)) dut (.CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(1'b1), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HREADY_I(hready), .HWDATA_I(hwdata),
    .DBG_HALT_I(halt), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .IRQ_O(irq), .CPU_RESET_O(cpu_rst));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    if (a == OFF_LOCK) lk = (d !== UNLOCK_KEY);
    else if (!lk && a == OFF_CTRL) mdl[a] = {29'h0, d[2:0] | mdl[a][2:0] & 3'h1};
    else if (!lk && mdl.exists(a)) mdl[a] = d;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  task automatic vdiff(input logic [31:0] e);
    xfer(1'b0, OFF_VALUE, 32'h0);
    v0 = r;
    xfer(1'b0, OFF_VALUE, 32'h0);
    chk(v0 - r, e);
  endtask
  task automatic wait_hi(input logic s, input int n);
    int   i;
    logic b;
    i = 0;
    do begin
      @(posedge clk);
      i++;
      b = s ? cpu_rst : irq;
    end while (b !== 1'b1 && i < n);
    chk({31'h0, b}, 32'h1);
    if (b !== 1'b1) wrap_up();
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 32'd41;
    rst_n = 1'b0;
    halt = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    lk = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    mdl[OFF_RELOAD] = RELOAD_RST;
    mdl[OFF_CTRL] = 32'h0;
    mdl[OFF_IMASK] = 32'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (mdl[a]) rc(a, mdl[a]);
    rc(OFF_STATUS, 32'h0);
    rc(8'h24, 32'h0);
    $display("reset values done");
    big = 32'h00010000 | rnd() & 32'hffff;
    wr(OFF_RELOAD, big);
    wr(OFF_IMASK, 32'h1);
    wr(OFF_CTRL, 32'h5);
    rc(OFF_STATUS, 32'h1);
    halt <= 1'b1;
    vdiff(32'h0);
    halt <= 1'b0;
    vdiff(32'h2);
    wr(OFF_CTRL, 32'h1);
    halt <= 1'b1;
    vdiff(32'h2);
    halt <= 1'b0;
    $display("stall done");
    wr(OFF_LOCK, rnd() & 32'hfff);
    rc(OFF_LOCK, 32'h1);
    rc(OFF_STATUS, 32'h3);
    wr(OFF_CTRL, 32'h7);
    wr(OFF_RELOAD, rnd());
    rc(OFF_CTRL, mdl[OFF_CTRL]);
    rc(OFF_RELOAD, mdl[OFF_RELOAD]);
    wr(OFF_LOCK, UNLOCK_KEY);
    rc(OFF_LOCK, 32'h0);
    sml = 32'd24 + (rnd() & 32'hf);
    wr(OFF_RELOAD, sml);
    rc(OFF_RELOAD, sml);
    $display("lock done");
    xfer(1'b0, OFF_VALUE, 32'h0);
    chk({31'h0, r <= sml}, 32'h1);
    wait_hi(1'b0, 2 * sml);
    rc(OFF_RIS, 32'h1);
    rc(OFF_MIS, 32'h1);
    repeat (2 * sml) begin
      @(posedge clk);
      chk({31'h0, cpu_rst}, 32'h0);
    end
    wr(OFF_RELOAD, sml);
    wr(OFF_ICLR, 32'h1);
    rc(OFF_RIS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_IMASK, 32'h0);
    repeat (sml + 8) @(posedge clk);
    rc(OFF_RIS, 32'h1);
    rc(OFF_MIS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_IMASK, 32'h1);
    $display("interrupt done");
    wr(OFF_CTRL, 32'h3);
    wait_hi(1'b1, 3 * sml);
    $display("processor reset done");
    wr(OFF_RELOAD, sml);
    wr(OFF_ICLR, 32'h1);
    rc(OFF_RIS, 32'h0);
    wr(OFF_RELOAD, 32'h0);
    wait_hi(1'b0, 4);
    $display("zero reload done");
    wrap_up();
  end
endmodule
`default_nettype wire
